/* fpw_pkg.sv */
// Shared constants, field layout and config carrier for the fan modulators
package fpw_pkg;

	// Widths and period structure
	localparam int FPW_DIV_W  = 13;
	localparam int FPW_DUTY_W = 6;
	localparam logic [FPW_DUTY_W-1:0] FPW_STEP_LAST = 6'h3F;

	// Clock sources in Hz
	localparam longint FPW_CLK_HZ  = 64'd20_000_000;
	localparam longint FPW_STBY_HZ = 64'd32_768;

	// Nominal output frequencies in millihertz, as printed
	localparam longint FPW_F_15K625 = 64'd15_625_000;
	localparam longint FPW_F_23K438 = 64'd23_438_000;
	localparam longint FPW_F_31K25  = 64'd31_250_000;
	localparam longint FPW_F_46K876 = 64'd46_876_000;
	localparam longint FPW_F_40     = 64'd40_000;
	localparam longint FPW_F_60     = 64'd60_000;
	localparam longint FPW_F_80     = 64'd80_000;
	localparam longint FPW_F_120    = 64'd120_000;
	localparam longint FPW_F_183    = 64'd183_100;
	localparam longint FPW_F_275    = 64'd275_000;
	localparam longint FPW_F_367    = 64'd366_660;
	localparam longint FPW_F_550    = 64'd550_000;
	localparam longint FPW_F_32     = 64'd32_000;
	localparam longint FPW_F_64     = 64'd64_000;
	localparam longint FPW_F_128    = 64'd128_000;

	// Source events per duty step, rounded to nearest so error stays inside 5%
	function automatic logic [FPW_DIV_W-1:0] fpw_div(longint src_hz, longint f_mhz);
		return FPW_DIV_W'((src_hz * 64'd1000 + f_mhz * 64'd32) / (f_mhz * 64'd64));
	endfunction

	localparam logic [FPW_DIV_W-1:0] FPW_DIV_15K625 = fpw_div(FPW_CLK_HZ, FPW_F_15K625);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_23K438 = fpw_div(FPW_CLK_HZ, FPW_F_23K438);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_31K25  = fpw_div(FPW_CLK_HZ, FPW_F_31K25);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_46K876 = fpw_div(FPW_CLK_HZ, FPW_F_46K876);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_40     = fpw_div(FPW_CLK_HZ, FPW_F_40);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_60     = fpw_div(FPW_CLK_HZ, FPW_F_60);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_80     = fpw_div(FPW_CLK_HZ, FPW_F_80);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_120    = fpw_div(FPW_CLK_HZ, FPW_F_120);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_183    = fpw_div(FPW_CLK_HZ, FPW_F_183);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_275    = fpw_div(FPW_CLK_HZ, FPW_F_275);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_367    = fpw_div(FPW_CLK_HZ, FPW_F_367);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_550    = fpw_div(FPW_CLK_HZ, FPW_F_550);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_S32    = fpw_div(FPW_STBY_HZ, FPW_F_32);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_S64    = fpw_div(FPW_STBY_HZ, FPW_F_64);
	localparam logic [FPW_DIV_W-1:0] FPW_DIV_S128   = fpw_div(FPW_STBY_HZ, FPW_F_128);

	// Mailbox indices
	localparam logic [7:0] FPW_MBX_SPD0 = 8'h92;
	localparam logic [7:0] FPW_MBX_SPD1 = 8'h93;
	localparam logic [7:0] FPW_MBX_SPD2 = 8'h95;
	localparam logic [7:0] FPW_MBX_CTRL = 8'h9D;

	// Microcontroller addresses
	localparam logic [15:0] FPW_UC_SPD0 = 16'h7F25;
	localparam logic [15:0] FPW_UC_SPD1 = 16'h7F26;
	localparam logic [15:0] FPW_UC_CTRL = 16'h7F28;
	localparam logic [15:0] FPW_UC_SPD2 = 16'h7F29;

	// Speed register fields
	localparam int FPW_SPD_FORCE  = 0;
	localparam int FPW_SPD_DUTY_L = 1;
	localparam int FPW_SPD_SEL0   = 7;

	// Control register fields
	localparam int FPW_CTL_SEL1_0 = 0;
	localparam int FPW_CTL_SEL1_1 = 1;
	localparam int FPW_CTL_MUL_0  = 2;
	localparam int FPW_CTL_MUL_1  = 3;
	localparam int FPW_CTL_STBY_0 = 4;
	localparam int FPW_CTL_STBY_1 = 5;
	localparam int FPW_CTL_SEL1_2 = 6;
	localparam int FPW_CTL_MUL_2  = 7;

	// Reset values
	localparam logic [7:0] FPW_SPD_RST  = 8'h00;
	localparam logic [7:0] FPW_CTRL_RST = 8'h30;
	localparam logic [7:0] FPW_RD_NONE  = 8'h00;

	// Per-channel settings handed to a modulator core
	typedef struct packed {
		logic                  force_hi;
		logic [FPW_DUTY_W-1:0] duty;
		logic                  stby;
		logic [FPW_DIV_W-1:0]  div;
	} fpw_cfg_t;

endpackage

/* fpw_chan.sv */
// One fan modulator core: prescaler, 64-step period counter, output flop
`timescale 1ns/10ps
`default_nettype none
module fpw_chan (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire fpw_pkg::fpw_cfg_t cfg_in,
	input  wire logic             stby_edge,
	output var  logic             pwm_out
);
	import fpw_pkg::*;

	fpw_cfg_t               cfg_q;
	logic [FPW_DIV_W-1:0]   pre_q;
	logic [FPW_DUTY_W-1:0]  step_q;
	logic                   out_q;

	// Standby channels advance only on standby clock edges
	wire                    src_en   = cfg_q.stby ? stby_edge : 1'b1;
	wire                    pre_last = ({1'b0, pre_q} + 14'h1) >= {1'b0, cfg_q.div};
	wire                    tick     = src_en && pre_last;
	wire                    boundary = tick && (step_q == FPW_STEP_LAST);
	wire                    out_d    = cfg_q.force_hi || (step_q < cfg_q.duty);

	// Prescaler and step counter; settings taken only at period end
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cfg_q  <= '0;
			pre_q  <= '0;
			step_q <= '0;
			out_q  <= 1'b0;
		end
		else
		begin
			if (src_en)
				pre_q <= tick ? '0 : pre_q + 1'b1;
			if (tick)
				step_q <= step_q + 1'b1;
			if (boundary)
				cfg_q <= cfg_in;
			out_q <= out_d;
		end
	end

	assign pwm_out = out_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_force_high;
		cfg_q.force_hi |=> out_q;
	endproperty
	a_force_high: assert property (p_force_high)
		else $error("forced channel output not high");

	property p_zero_low;
		!cfg_q.force_hi && (cfg_q.duty == '0) ##1 !cfg_q.force_hi |-> !out_q;
	endproperty
	a_zero_low: assert property (p_zero_low)
		else $error("zero duty output not low");

	property p_last_step_low;
		!cfg_q.force_hi && (step_q == FPW_STEP_LAST) |=> !out_q;
	endproperty
	a_last_step_low: assert property (p_last_step_low)
		else $error("last step of period not low");

	property p_cfg_at_boundary;
		!$stable(cfg_q) |-> $past(boundary);
	endproperty
	a_cfg_at_boundary: assert property (p_cfg_at_boundary)
		else $error("settings changed mid period");

	property p_stby_gated;
		cfg_q.stby && !stby_edge |=> $stable(pre_q) && $stable(step_q);
	endproperty
	a_stby_gated: assert property (p_stby_gated)
		else $error("standby channel advanced without a standby edge");

	c_boundary: cover property (boundary && !cfg_q.force_hi && (cfg_q.duty != '0));
endmodule
`default_nettype wire

/* fpw_top.sv */
// Three fan modulators with speed and control registers on two access ports
// Summary of operation
// - Speed registers for channels 0,1,2 sit at mailbox indices 0x92, 0x93, 0x95.
// - Each speed register resets to 0x00, so the output sits low.
// - Channels 0,1 reset on standby-plane reset; channel 2 on main-plane reset.
// - Mailbox and microcontroller both read and write every speed register bit.
// - Channels 0,1: bit 0 forces high; else duty/64 high, zero stays low.
// - Channels 0,1 doubler is control bit 2 or 3, ignored on standby clock.
// - Channels 0,1 upper select is control bit 0 or 1, choosing frequency.
// - Channels 0,1 lower select is bit 7 of their speed register.
// - Standby clock bit set gives 32, 64, 128 Hz; code 11 reserved.
// - Channel 2: bit 0 forces high, otherwise duty field acts as elsewhere.
// - Channel 2 doubler is control bit 7 and applies to every code.
// - Channel 2 upper select is control bit 6; set gives 183.1 to 550 Hz.
// - Channel 2 lower select is bit 7 of its speed register.
// - Channel 2 upper select clear gives 15.625 to 46.876 kHz.
// - Frequencies within 5 percent; channel 2 at 275 Hz within 10 Hz.
// - Channels 0,1 on system clock give kHz or 40/60 Hz, doubled optionally.
// - Channel 2 runs only from the system clock, never from standby.
// - Duty field is speed bits 6..1; maximum gives 63/64 high.
`timescale 1ns/10ps
`default_nettype none
module fpw_top #(
	parameter logic [fpw_pkg::FPW_DIV_W-1:0] DIV_40HZ = fpw_pkg::FPW_DIV_40,
	parameter logic [fpw_pkg::FPW_DIV_W-1:0] DIV_60HZ = fpw_pkg::FPW_DIV_60
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        main_reset,
	input  wire logic        standby_clk,
	input  wire logic [7:0]  mbx_index,
	input  wire logic        mbx_wr,
	input  wire logic        mbx_rd,
	input  wire logic [7:0]  mbx_wdata,
	output var  logic [7:0]  mbx_rdata,
	input  wire logic [15:0] uc_addr,
	input  wire logic        uc_wr,
	input  wire logic        uc_rd,
	input  wire logic [7:0]  uc_wdata,
	output var  logic [7:0]  uc_rdata,
	output var  logic        fan_chan_0,
	output var  logic        fan_chan_1,
	output var  logic        fan_chan_2
);
	import fpw_pkg::*;

	logic [7:0] spd0_q;
	logic [7:0] spd1_q;
	logic [7:0] spd2_q;
	logic [7:0] ctrl_q;
	logic [7:0] mbx_rdata_q;
	logic [7:0] uc_rdata_q;
	logic       stby_s1_q;
	logic       stby_s2_q;
	logic       stby_s3_q;

	// Mailbox wins when both ports write the same register in one cycle
	function automatic logic [7:0] wr_merge(logic [7:0] cur, logic mhit, logic uhit,
		logic [7:0] mdat, logic [7:0] udat);
		return mhit ? mdat : (uhit ? udat : cur);
	endfunction

	// Register read select; unmapped locations read as zero
	function automatic logic [7:0] rd_sel(logic h0, logic h1, logic h2, logic hc,
		logic [7:0] r0, logic [7:0] r1, logic [7:0] r2, logic [7:0] rc);
		return h0 ? r0 : (h1 ? r1 : (h2 ? r2 : (hc ? rc : FPW_RD_NONE)));
	endfunction

	// Step divider for channels 0 and 1
	function automatic logic [FPW_DIV_W-1:0] ch01_div(logic stby, logic mul, logic sel1,
		logic sel0);
		logic [FPW_DIV_W-1:0] d;
		d = FPW_DIV_15K625;
		if (stby)
			unique case ({sel1, sel0})
				2'b00: d = FPW_DIV_S32;
				2'b01: d = FPW_DIV_S64;
				2'b10: d = FPW_DIV_S128;
				2'b11: d = FPW_DIV_S128;
			endcase
		else
			unique case ({mul, sel1, sel0})
				3'b000: d = FPW_DIV_15K625;
				3'b001: d = FPW_DIV_23K438;
				3'b010: d = DIV_40HZ;
				3'b011: d = DIV_60HZ;
				3'b100: d = FPW_DIV_31K25;
				3'b101: d = FPW_DIV_46K876;
				3'b110: d = FPW_DIV_80;
				3'b111: d = FPW_DIV_120;
			endcase
		return d;
	endfunction

	// Step divider for channel 2, system clock only
	function automatic logic [FPW_DIV_W-1:0] ch2_div(logic sel1, logic mul, logic sel0);
		logic [FPW_DIV_W-1:0] d;
		d = FPW_DIV_15K625;
		unique case ({sel1, mul, sel0})
			3'b000: d = FPW_DIV_15K625;
			3'b001: d = FPW_DIV_23K438;
			3'b010: d = FPW_DIV_31K25;
			3'b011: d = FPW_DIV_46K876;
			3'b100: d = FPW_DIV_183;
			3'b101: d = FPW_DIV_275;
			3'b110: d = FPW_DIV_367;
			3'b111: d = FPW_DIV_550;
		endcase
		return d;
	endfunction

	// Address decode on both access ports
	wire mh0 = mbx_index == FPW_MBX_SPD0;
	wire mh1 = mbx_index == FPW_MBX_SPD1;
	wire mh2 = mbx_index == FPW_MBX_SPD2;
	wire mhc = mbx_index == FPW_MBX_CTRL;
	wire uh0 = uc_addr == FPW_UC_SPD0;
	wire uh1 = uc_addr == FPW_UC_SPD1;
	wire uh2 = uc_addr == FPW_UC_SPD2;
	wire uhc = uc_addr == FPW_UC_CTRL;

	// Next register values, full byte writable from either port
	wire [7:0] spd0_d = wr_merge(spd0_q, mbx_wr && mh0, uc_wr && uh0, mbx_wdata, uc_wdata);
	wire [7:0] spd1_d = wr_merge(spd1_q, mbx_wr && mh1, uc_wr && uh1, mbx_wdata, uc_wdata);
	wire [7:0] spd2_d = wr_merge(spd2_q, mbx_wr && mh2, uc_wr && uh2, mbx_wdata, uc_wdata);
	wire [7:0] ctrl_d = wr_merge(ctrl_q, mbx_wr && mhc, uc_wr && uhc, mbx_wdata, uc_wdata);
	wire [7:0] mbx_rdata_d = rd_sel(mh0, mh1, mh2, mhc, spd0_q, spd1_q, spd2_q, ctrl_q);
	wire [7:0] uc_rdata_d  = rd_sel(uh0, uh1, uh2, uhc, spd0_q, spd1_q, spd2_q, ctrl_q);

	// Standby clock sampled thrice; only the later stages feed the edge detect
	wire stby_edge = stby_s2_q && !stby_s3_q;

	// Settings for each modulator core
	fpw_cfg_t cfg0;
	fpw_cfg_t cfg1;
	fpw_cfg_t cfg2;
	assign cfg0 = '{force_hi: spd0_q[FPW_SPD_FORCE],
		duty: spd0_q[FPW_SPD_DUTY_L +: FPW_DUTY_W],
		stby: ctrl_q[FPW_CTL_STBY_0],
		div: ch01_div(ctrl_q[FPW_CTL_STBY_0], ctrl_q[FPW_CTL_MUL_0],
			ctrl_q[FPW_CTL_SEL1_0], spd0_q[FPW_SPD_SEL0])};
	assign cfg1 = '{force_hi: spd1_q[FPW_SPD_FORCE],
		duty: spd1_q[FPW_SPD_DUTY_L +: FPW_DUTY_W],
		stby: ctrl_q[FPW_CTL_STBY_1],
		div: ch01_div(ctrl_q[FPW_CTL_STBY_1], ctrl_q[FPW_CTL_MUL_1],
			ctrl_q[FPW_CTL_SEL1_1], spd1_q[FPW_SPD_SEL0])};
	assign cfg2 = '{force_hi: spd2_q[FPW_SPD_FORCE],
		duty: spd2_q[FPW_SPD_DUTY_L +: FPW_DUTY_W],
		stby: 1'b0,
		div: ch2_div(ctrl_q[FPW_CTL_SEL1_2], ctrl_q[FPW_CTL_MUL_2],
			spd2_q[FPW_SPD_SEL0])};

	// Standby-plane registers and read data
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			spd0_q      <= FPW_SPD_RST;
			spd1_q      <= FPW_SPD_RST;
			ctrl_q      <= FPW_CTRL_RST;
			mbx_rdata_q <= FPW_RD_NONE;
			uc_rdata_q  <= FPW_RD_NONE;
			stby_s1_q   <= 1'b0;
			stby_s2_q   <= 1'b0;
			stby_s3_q   <= 1'b0;
		end
		else
		begin
			spd0_q      <= spd0_d;
			spd1_q      <= spd1_d;
			ctrl_q      <= ctrl_d;
			mbx_rdata_q <= mbx_rd ? mbx_rdata_d : mbx_rdata_q;
			uc_rdata_q  <= uc_rd ? uc_rdata_d : uc_rdata_q;
			stby_s1_q   <= standby_clk;
			stby_s2_q   <= stby_s1_q;
			stby_s3_q   <= stby_s2_q;
		end
	end

	// Main-plane register: lost whenever the main supply comes back
	always_ff @(posedge core_clk)
	begin
		if (main_reset)
			spd2_q <= FPW_SPD_RST;
		else
			spd2_q <= spd2_d;
	end

	assign mbx_rdata = mbx_rdata_q;
	assign uc_rdata  = uc_rdata_q;

	// Modulator cores; channel 2 follows the main-plane reset
	fpw_chan u_chan0 (
		.core_clk  (core_clk),
		.rst       (reset),
		.cfg_in    (cfg0),
		.stby_edge (stby_edge),
		.pwm_out   (fan_chan_0)
	);
	fpw_chan u_chan1 (
		.core_clk  (core_clk),
		.rst       (reset),
		.cfg_in    (cfg1),
		.stby_edge (stby_edge),
		.pwm_out   (fan_chan_1)
	);
	fpw_chan u_chan2 (
		.core_clk  (core_clk),
		.rst       (main_reset),
		.cfg_in    (cfg2),
		.stby_edge (stby_edge),
		.pwm_out   (fan_chan_2)
	);

	property p_spd_reset;
		@(posedge core_clk) disable iff (main_reset)
		reset |=> (spd0_q == FPW_SPD_RST) && (spd1_q == FPW_SPD_RST) && !fan_chan_0;
	endproperty
	a_spd_reset: assert property (p_spd_reset)
		else $error("standby-plane reset left speed state");

	property p_main_only;
		@(posedge core_clk) disable iff (reset)
		main_reset && !mbx_wr && !uc_wr |=> (spd2_q == FPW_SPD_RST) && $stable(spd0_q)
			&& $stable(spd1_q);
	endproperty
	a_main_only: assert property (p_main_only)
		else $error("main-plane reset touched the wrong registers");

	property p_mbx_wr1;
		@(posedge core_clk) disable iff (reset)
		mbx_wr && (mbx_index == FPW_MBX_SPD1) |=> spd1_q == $past(mbx_wdata);
	endproperty
	a_mbx_wr1: assert property (p_mbx_wr1)
		else $error("mailbox write to channel 1 speed lost");

	property p_uc_rd0;
		@(posedge core_clk) disable iff (reset)
		uc_rd && (uc_addr == FPW_UC_SPD0) |=> uc_rdata == $past(spd0_q);
	endproperty
	a_uc_rd0: assert property (p_uc_rd0)
		else $error("microcontroller read of channel 0 speed wrong");

	property p_stby_32;
		@(posedge core_clk) disable iff (reset)
		ctrl_q[FPW_CTL_STBY_0] && !ctrl_q[FPW_CTL_SEL1_0] && !spd0_q[FPW_SPD_SEL0]
			|-> cfg0.div == FPW_DIV_S32;
	endproperty
	a_stby_32: assert property (p_stby_32)
		else $error("standby 32 Hz divider wrong");

	property p_stby_no_mul;
		@(posedge core_clk) disable iff (reset)
		ctrl_q[FPW_CTL_STBY_1] && ctrl_q[FPW_CTL_MUL_1] && ctrl_q[FPW_CTL_SEL1_1]
			&& !spd1_q[FPW_SPD_SEL0] |-> cfg1.div == FPW_DIV_S128;
	endproperty
	a_stby_no_mul: assert property (p_stby_no_mul)
		else $error("doubler acted on standby clock");

	property p_sys_40;
		@(posedge core_clk) disable iff (reset)
		!ctrl_q[FPW_CTL_STBY_0] && !ctrl_q[FPW_CTL_MUL_0] && ctrl_q[FPW_CTL_SEL1_0]
			&& !spd0_q[FPW_SPD_SEL0] |-> cfg0.div == DIV_40HZ;
	endproperty
	a_sys_40: assert property (p_sys_40)
		else $error("40 Hz divider wrong");

	property p_ch2_fast;
		@(posedge core_clk) disable iff (main_reset)
		!ctrl_q[FPW_CTL_SEL1_2] && ctrl_q[FPW_CTL_MUL_2] && spd2_q[FPW_SPD_SEL0]
			|-> cfg2.div == FPW_DIV_46K876;
	endproperty
	a_ch2_fast: assert property (p_ch2_fast)
		else $error("channel 2 fast divider wrong");

	property p_ch2_275;
		@(posedge core_clk) disable iff (main_reset)
		ctrl_q[FPW_CTL_SEL1_2] && !ctrl_q[FPW_CTL_MUL_2] && spd2_q[FPW_SPD_SEL0]
			|-> cfg2.div == FPW_DIV_275;
	endproperty
	a_ch2_275: assert property (p_ch2_275)
		else $error("channel 2 275 Hz divider wrong");

	c_stby_out: cover property (@(posedge core_clk) disable iff (reset)
		ctrl_q[FPW_CTL_STBY_0] && fan_chan_0);
	c_ch2_high: cover property (@(posedge core_clk) disable iff (main_reset)
		fan_chan_2 ##1 !fan_chan_2);
	c_uc_write: cover property (@(posedge core_clk) disable iff (reset)
		uc_wr && uh1 ##1 fan_chan_1);
endmodule
`default_nettype wire

/* fpw_fan_model.sv */
// Fan drive model: times each output period and its high part
`timescale 1ns/10ps
`default_nettype none
module fpw_fan_model (
	input  wire logic        core_clk,
	input  wire logic        fan_in,
	output var  logic [31:0] period_cyc,
	output var  logic [31:0] high_cyc,
	output var  logic [31:0] rise_cnt
);
	logic        prev_q = 1'b0;
	logic [31:0] cnt_q  = 32'h0;
	logic [31:0] hi_q   = 32'h0;

	initial rise_cnt = 32'h0;

	// A fan sees rising edges only; unknown levels never count as high
	always @(posedge core_clk)
	begin
		prev_q <= (fan_in === 1'b1);
		if (fan_in === 1'b1 && !prev_q)
		begin
			period_cyc <= cnt_q;
			high_cyc   <= hi_q;
			cnt_q      <= 32'h1;
			hi_q       <= 32'h1;
			rise_cnt   <= rise_cnt + 32'h1;
		end
		else
		begin
			cnt_q <= cnt_q + 32'h1;
			hi_q  <= hi_q + ((fan_in === 1'b1) ? 32'h1 : 32'h0);
		end
	end
endmodule
`default_nettype wire

/* fan_pwm_speed_control_tb.sv */
// Self-checking bench for the three fan modulators and their registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module fan_pwm_speed_control_tb;
	import fpw_pkg::*;

	localparam int     DIV40    = 40;
	localparam int     DIV60    = 60;
	// Standby clock sped up to 5 core cycles so slow modes fit the run
	localparam longint STBY_CYC = 5;

	typedef struct {
		int         ch;
		logic [7:0] ctl;
		logic [7:0] spd;
		longint     nom;
	} fpw_case_t;

	logic        core_clk, reset, main_reset, standby_clk;
	logic [7:0]  mbx_index, mbx_wdata, mbx_rdata, uc_wdata, uc_rdata;
	logic        mbx_wr, mbx_rd, uc_wr, uc_rd;
	logic [15:0] uc_addr;
	logic        fan_chan_0, fan_chan_1, fan_chan_2;
	wire  [2:0]  fan_w = {fan_chan_2, fan_chan_1, fan_chan_0};
	logic [31:0] per_c [3];
	logic [31:0] hi_c [3];
	logic [31:0] rc_c [3];
	int          err_total  = 0;
	int          n_compared = 0;

	function automatic longint nsys(longint f);
		return FPW_CLK_HZ * 1000 / f;
	endfunction
	function automatic longint nstb(longint f);
		return FPW_STBY_HZ * 1000 * STBY_CYC / f;
	endfunction

	// Channel 2 codes, standby bits ignored
	// Channels 0/1 system and standby codes
	fpw_case_t tbl [16] = '{
		'{2, 8'h00, 8'h02, nsys(FPW_F_15K625)}, '{2, 8'h00, 8'hFE, nsys(FPW_F_23K438)},
		'{2, 8'h80, 8'h40, nsys(FPW_F_31K25)},  '{2, 8'h80, 8'hC0, nsys(FPW_F_46K876)},
		'{2, 8'h30, 8'h40, nsys(FPW_F_15K625)}, '{0, 8'h00, 8'h40, nsys(FPW_F_15K625)},
		'{0, 8'h00, 8'hC0, nsys(FPW_F_23K438)}, '{0, 8'h04, 8'h40, nsys(FPW_F_31K25)},
		'{0, 8'h04, 8'hC0, nsys(FPW_F_46K876)}, '{0, 8'h01, 8'h40, 64 * DIV40},
		'{1, 8'h08, 8'hC0, nsys(FPW_F_46K876)}, '{1, 8'h02, 8'hC0, 64 * DIV60},
		'{0, 8'h11, 8'h40, nstb(FPW_F_128)},    '{0, 8'h15, 8'h40, nstb(FPW_F_128)},
		'{0, 8'h10, 8'hC0, nstb(FPW_F_64)},     '{1, 8'h2A, 8'h40, nstb(FPW_F_128)}
	};
	logic [7:0] spd_idx [3] = '{FPW_MBX_SPD0, FPW_MBX_SPD1, FPW_MBX_SPD2};

	fpw_top #(
		.DIV_40HZ(13'(DIV40)),
		.DIV_60HZ(13'(DIV60))
	) i_dut (
		.core_clk(core_clk), .reset(reset), .main_reset(main_reset),
		.standby_clk(standby_clk), .mbx_index(mbx_index), .mbx_wr(mbx_wr),
		.mbx_rd(mbx_rd), .mbx_wdata(mbx_wdata), .mbx_rdata(mbx_rdata),
		.uc_addr(uc_addr), .uc_wr(uc_wr), .uc_rd(uc_rd), .uc_wdata(uc_wdata),
		.uc_rdata(uc_rdata), .fan_chan_0(fan_chan_0), .fan_chan_1(fan_chan_1),
		.fan_chan_2(fan_chan_2)
	);

	// One fan per modulator output
	for (genvar g = 0; g < 3; g++)
	begin : g_fan
		fpw_fan_model i_fan (
			.core_clk(core_clk), .fan_in(fan_w[g]), .period_cyc(per_c[g]),
			.high_cyc(hi_c[g]), .rise_cnt(rc_c[g])
		);
	end

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		standby_clk = 1'b0;
		// Offset keeps standby edges clear of the core sampling edge
		#5;
		forever #125 standby_clk = ~standby_clk;
	end

	task automatic step;
		@(posedge core_clk);
		#5;
	endtask

	task automatic complete_run;
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One-cycle write strobe, then an idle cycle before the next access
	task automatic reg_wr(bit uc, logic [15:0] a, logic [7:0] d);
		if (uc)
		begin
			uc_addr = a; uc_wdata = d; uc_wr = 1'b1;
		end
		else
		begin
			mbx_index = a[7:0]; mbx_wdata = d; mbx_wr = 1'b1;
		end
		step;
		uc_wr = 1'b0;
		mbx_wr = 1'b0;
		step;
	endtask

	// Read data is registered at the strobe edge and compared just after
	task automatic reg_rd(bit uc, logic [15:0] a, logic [7:0] exp);
		if (uc)
		begin
			uc_addr = a; uc_rd = 1'b1;
		end
		else
		begin
			mbx_index = a[7:0]; mbx_rd = 1'b1;
		end
		step;
		uc_rd = 1'b0;
		mbx_rd = 1'b0;
		`CHK(uc ? uc_rdata : mbx_rdata, exp)
		step;
	endtask

	// Third rise after a change is surely a whole new-setting period
	task automatic meas(int ch, logic [5:0] duty, longint nom);
		logic [31:0] r0;
		longint      d;
		int          k;
		r0 = rc_c[ch];
		k = 0;
		while (rc_c[ch] - r0 < 32'd3 && k < 40000)
		begin
			step;
			k++;
		end
		if (k >= 40000)
		begin
			err_total++;
			complete_run;
		end
		d = longint'(per_c[ch]) - nom;
		if (d < 0)
			d = -d;
		// Tolerance is on frequency, so the error is relative to the measured period
		`CHK(d * 20 <= longint'(per_c[ch]), 1'b1)
		`CHK(hi_c[ch], 32'(per_c[ch] * duty / 64))
	endtask

	task automatic run_case(int i);
		reg_wr(0, FPW_MBX_CTRL, tbl[i].ctl);
		reg_wr(0, spd_idx[tbl[i].ch], tbl[i].spd);
		meas(tbl[i].ch, tbl[i].spd[6:1], tbl[i].nom);
	endtask

	// Output must sit at one level once the running period has ended
	task automatic lvl_chk(int ch, logic [7:0] spd, logic lvl);
		int bad;
		bad = 0;
		reg_wr(0, FPW_MBX_CTRL, 8'h00);
		reg_wr(0, spd_idx[ch], spd);
		repeat (4000) step;
		repeat (1500)
		begin
			step;
			if (fan_w[ch] !== lvl)
				bad++;
		end
		`CHK(bad, 0)
	endtask

	initial
	begin
		{reset, main_reset} = 2'b11;
		{mbx_wr, mbx_rd, uc_wr, uc_rd} = 4'h0;
		mbx_index = 8'h00; mbx_wdata = 8'h00; uc_addr = 16'h0000; uc_wdata = 8'h00;
		repeat (5) step;
		{reset, main_reset} = 2'b00;
		step;
		reg_rd(0, FPW_MBX_SPD0, 8'h00);
		reg_rd(0, FPW_MBX_SPD1, 8'h00);
		reg_rd(0, FPW_MBX_SPD2, 8'h00);
		reg_rd(0, FPW_MBX_CTRL, 8'h30);
		reg_rd(1, FPW_UC_SPD1, 8'h00);
		reg_wr(0, 8'h94, 8'hFF);
		reg_rd(0, 8'h94, 8'h00);
		reg_wr(0, FPW_MBX_SPD0, 8'hA5);
		reg_wr(1, FPW_UC_SPD1, 8'h5A);
		reg_wr(1, FPW_UC_SPD2, 8'hC3);
		reg_rd(1, FPW_UC_SPD0, 8'hA5);
		reg_rd(0, FPW_MBX_SPD1, 8'h5A);
		reg_rd(0, FPW_MBX_SPD2, 8'hC3);
		reg_wr(1, FPW_UC_CTRL, 8'h40);
		reg_rd(0, FPW_MBX_CTRL, 8'h40);
		reg_wr(1, FPW_UC_SPD0, 8'h3C);
		reg_rd(0, FPW_MBX_SPD0, 8'h3C);
		$display("Test registers done");
		reset = 1'b1;
		repeat (2) step;
		reset = 1'b0;
		step;
		reg_rd(0, FPW_MBX_SPD0, 8'h00);
		reg_rd(0, FPW_MBX_SPD2, 8'hC3);
		reg_wr(0, FPW_MBX_SPD1, 8'h77);
		main_reset = 1'b1;
		repeat (2) step;
		main_reset = 1'b0;
		step;
		reg_rd(0, FPW_MBX_SPD2, 8'h00);
		reg_rd(1, FPW_UC_SPD1, 8'h77);
		$display("Test reset planes done");
		for (int i = 0; i < 12; i++)
			run_case(i);
		$display("Test system clock rates done");
		lvl_chk(2, 8'h01, 1'b1);
		lvl_chk(2, 8'h80, 1'b0);
		lvl_chk(0, 8'hFF, 1'b1);
		lvl_chk(0, 8'h00, 1'b0);
		$display("Test fixed levels done");
		for (int i = 12; i < 16; i++)
			run_case(i);
		$display("Test standby rates done");
		complete_run;
	end
endmodule
`default_nettype wire
